// File: logic/prds_top.sv
/*
 * Single-output PWM stage: pulse steering onto four pins, dead-band delay on
 * active-going edges, auto-shutdown with optional auto-restart.
 * Assumes clk is the oscillator clock (instruction cycle = 4 clocks); a stopped
 * clk models sleep, so all state freezes and pins hold.
 */
// Summary of operation
// - Auto-restart set: flag clears itself when shutdown input drops, PWM resumes.
// - Active-going edges are delayed by the seven-bit count of instruction cycles.
// - Steering works only with mode upper bits 11 and bridge mode 00.
// - Same PWM signal appears on every enabled pin simultaneously.
// - Each enable routes PWM to its pin; clear gives the pin back to port.
// - Mode lower bits set polarity of all steered pins.
// - Shutdown changes only pins with PWM output enabled.
// - Sync clear: new steering applies at end of the writing instruction.
// - Sync set: new steering applies at start of next PWM period.
// - Without clock everything freezes and pins hold their level.
// - Module runs from whichever clock is supplied in idle modes.
// - On clock failure the module continues on the fallback clock supplied.
// - Reset makes pins inputs and registers return to reset values.
// - Steering register top bits read zero; reset enables output A only.
// - With auto-restart the flag stays set while shutdown persists.
// - After restart output resumes only at the next period start.
// - Dead band applies only to inactive-to-active edges.
`default_nettype none
module prds_top
    import prds_pkg::*;
#(
    parameter int DB_W = 7
) (
    input wire logic clk, // Oscillator clock
    input wire logic reset, // Synchronous reset, active high
    input wire prds_pkg::prds_bus_t bus, // Register port request
    output logic [7:0] rdata, // Read data, cycle after read strobe
    input wire logic pwm_raw, // Unsteered PWM, active high
    input wire logic period_start, // Pulse at each period start
    input wire logic shutdown_in, // Shutdown condition level
    input wire logic [3:0] pin_direction_bits, // 0 means pin is output
    input wire logic [3:0] port_out, // Ordinary port output levels
    output var prds_pkg::prds_pins_t pins // Pin levels and enables
);
    import prds_pkg::*;

    logic [7:0] restart_db;
    logic [7:0] steer_reg;
    logic [7:0] mode_reg;
    logic [6:0] shut_cfg;
    logic shutdown_event_flag;
    logic [3:0] steer_live;
    logic steer_pending;
    logic [1:0] phase;
    logic instr_edge;
    logic [DB_W-1:0] db_cnt;
    logic pwm_db;
    logic pwm_db_prev_raw;
    logic held_off;
    logic steer_mode;
    logic [3:0] next_out;
    logic [3:0] next_oe;
    logic auto_restart_enable;
    logic steer_sync_select;
    logic [DB_W-1:0] dead_band_count;
    logic [1:0] polarity;

    assign auto_restart_enable = restart_db[RESTART_BIT];
    assign dead_band_count = restart_db[DB_W-1:0];
    assign steer_sync_select = steer_reg[SYNC_BIT];
    assign polarity = mode_reg[1:0];
    assign steer_mode = (mode_reg[3:2] == MODE_PWM_HI) && (mode_reg[7:6] == BRIDGE_SINGLE);

    // runs on whatever clk is supplied
    // Idle and fallback clocks just change clk; a stopped clk freezes every flop
    always_ff @(posedge clk)
    begin
        if (reset)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end
    assign instr_edge = (phase == 2'(OSC_PER_INSTR - 1));

    // registers to reset values, steering reset 0x01
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            restart_db <= RST_RESTART_DB;
            steer_reg <= RST_STEER;
            mode_reg <= RST_MODE;
            shut_cfg <= RST_SHUTDOWN[6:0];
        end
        else if (bus.wr)
        begin
            unique case (bus.addr)
                REG_RESTART_DB: restart_db <= bus.wdata;
                REG_STEER: steer_reg <= {3'h0, bus.wdata[4:0]};
                REG_MODE: mode_reg <= bus.wdata;
                REG_SHUTDOWN: shut_cfg <= bus.wdata[6:0];
            endcase
        end
    end

    // Shutdown event flag; hardware set wins over software clear
    always_ff @(posedge clk)
    begin
        if (reset)
            shutdown_event_flag <= 1'b0;
        else if (shutdown_in)
            shutdown_event_flag <= 1'b1;
        else if (auto_restart_enable && instr_edge)
            shutdown_event_flag <= 1'b0;
        else if (bus.wr && bus.addr == REG_SHUTDOWN)
            shutdown_event_flag <= bus.wdata[EVENT_BIT];
    end

    // Output held off after shutdown until next period start
    always_ff @(posedge clk)
    begin
        if (reset)
            held_off <= 1'b0;
        else if (shutdown_event_flag)
            held_off <= 1'b1;
        // resume only at next period boundary
        else if (period_start)
            held_off <= 1'b0;
    end

    // Steering update, immediate or period-synchronised
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            steer_live <= RST_STEER[3:0];
            steer_pending <= 1'b0;
        end
        else
        begin
            // take new enables at period start
            if (steer_pending && steer_sync_select && period_start)
            begin
                steer_live <= steer_reg[3:0];
                steer_pending <= 1'b0;
            end
            else if (steer_pending && !steer_sync_select && instr_edge)
            begin
                steer_live <= steer_reg[3:0];
                steer_pending <= 1'b0;
            end
            // Set last so a write landing on an apply edge is not lost
            if (bus.wr && bus.addr == REG_STEER)
                steer_pending <= 1'b1;
        end
    end

    // Dead band on active-going edges
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            db_cnt <= '0;
            pwm_db <= 1'b0;
            pwm_db_prev_raw <= 1'b0;
        end
        else
        begin
            pwm_db_prev_raw <= pwm_raw;
            if (!pwm_raw)
            begin
                pwm_db <= 1'b0;
                db_cnt <= '0;
            end
            // load count on rising edge; zero means no delay
            else if (!pwm_db_prev_raw)
            begin
                db_cnt <= dead_band_count;
                pwm_db <= (dead_band_count == '0);
            end
            else if (!pwm_db && instr_edge)
            begin
                if (db_cnt <= DB_W'(1))
                    pwm_db <= 1'b1;
                db_cnt <= db_cnt - DB_W'(1);
            end
        end
    end

    // Pin mux, one generate per pin
    for (genvar i = 0; i < 4; i++)
    begin : g_pin
        logic pol_low;
        logic shut_lvl;
        logic shut_z;
        // A/C use polarity bit 1 and shutdown bits 2/3; B/D use polarity bit 0 and shutdown bits 0/1
        assign pol_low = (i == 0 || i == 2) ? polarity[1] : polarity[0];
        assign shut_lvl = (i == 0 || i == 2) ? shut_cfg[2] : shut_cfg[0];
        assign shut_z = (i == 0 || i == 2) ? shut_cfg[3] : shut_cfg[1];
        always_comb
        begin
            // enabled pins carry PWM, others port
            if (steer_mode && steer_live[i])
            begin
                if (shutdown_event_flag || held_off)
                begin
                    next_out[i] = shut_lvl;
                    next_oe[i] = !shut_z && !pin_direction_bits[i];
                end
                else
                begin
                    next_out[i] = pwm_db ^ pol_low;
                    next_oe[i] = !pin_direction_bits[i];
                end
            end
            else
            begin
                next_out[i] = port_out[i];
                next_oe[i] = !pin_direction_bits[i];
            end
        end
    end

    // pins are inputs during reset; outputs hold when clk stops
    always_ff @(posedge clk)
    begin
        if (reset)
            pins <= '0;
        else
            pins <= '{out: next_out, oe: next_oe};
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            rdata <= 8'h00;
        else if (bus.rd)
        begin
            unique case (bus.addr)
                REG_RESTART_DB: rdata <= restart_db;
                REG_STEER: rdata <= steer_reg;
                REG_MODE: rdata <= mode_reg;
                REG_SHUTDOWN: rdata <= {shutdown_event_flag, shut_cfg};
            endcase
        end
    end

    // Assertions
    // Checks on pins look one cycle on, since the pin register adds a stage
    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (reset)
        shutdown_in |=> shutdown_event_flag)
        else $error("flag dropped during shutdown");

    // Four quiet cycles always hold one instruction boundary; the clear lands one later
    AST_AUTO_CLEAR: assert property (@(posedge clk) disable iff (reset)
        (auto_restart_enable && !shutdown_in && !bus.wr) [*4] |=> !shutdown_event_flag)
        else $error("auto restart did not clear flag");

    AST_NO_AUTO: assert property (@(posedge clk) disable iff (reset)
        (shutdown_event_flag && !auto_restart_enable && !bus.wr) |=> shutdown_event_flag)
        else $error("flag cleared without software");

    AST_TOP_ZERO: assert property (@(posedge clk) disable iff (reset)
        steer_reg[7:5] == 3'h0)
        else $error("steering upper bits not zero");

    AST_RD_TOP_ZERO: assert property (@(posedge clk) disable iff (reset)
        (bus.rd && bus.addr == REG_STEER) |=> rdata[7:5] == 3'h0)
        else $error("steering read shows upper bits");

    AST_RESET_PINS: assert property (@(posedge clk) disable iff (reset)
        $past(reset) |-> (pins == '0 && rdata == 8'h00))
        else $error("pins not inputs after reset");

    AST_PORT_PIN: assert property (@(posedge clk) disable iff (reset)
        (!steer_mode && !$past(reset)) |=> pins.out == $past(port_out))
        else $error("port function lost");

    AST_MODE_GATE: assert property (@(posedge clk) disable iff (reset)
        !steer_mode |=> pins.oe == $past(~pin_direction_bits))
        else $error("steering active outside single output mode");

    AST_DIR_OE: assert property (@(posedge clk) disable iff (reset)
        pin_direction_bits[0] |=> !pins.oe[0])
        else $error("input pin driven");

    AST_STEERED_PWM: assert property (@(posedge clk) disable iff (reset)
        (steer_mode && steer_live[0] && !shutdown_event_flag && !held_off)
        |=> pins.out[0] == $past(pwm_db ^ polarity[1]))
        else $error("steered pin lost the waveform");

    AST_STEERED_POL: assert property (@(posedge clk) disable iff (reset)
        (steer_mode && steer_live[1] && !shutdown_event_flag && !held_off)
        |=> pins.out[1] == $past(pwm_db ^ polarity[0]))
        else $error("steered pin polarity wrong");

    AST_SHUT_PIN: assert property (@(posedge clk) disable iff (reset)
        (steer_mode && steer_live[0] && shutdown_event_flag) |=> pins.out[0] == $past(shut_cfg[2]))
        else $error("enabled pin not in shutdown state");

    // A port pin must never be disturbed by a shutdown it does not take part in
    AST_SHUT_SPARE: assert property (@(posedge clk) disable iff (reset)
        (!steer_live[1] && shutdown_event_flag) |=> pins.out[1] == $past(port_out[1]))
        else $error("shutdown touched a port pin");

    AST_NO_DB_FALL: assert property (@(posedge clk) disable iff (reset)
        !pwm_raw |=> !pwm_db)
        else $error("falling edge delayed");

    AST_DB_WAIT: assert property (@(posedge clk) disable iff (reset)
        (pwm_raw && !pwm_db_prev_raw && dead_band_count != '0) |=> !pwm_db)
        else $error("dead band skipped");

    AST_ZERO_DB: assert property (@(posedge clk) disable iff (reset)
        (pwm_raw && !pwm_db_prev_raw && dead_band_count == '0) |=> pwm_db)
        else $error("zero dead band delayed");

    AST_HELD_SET: assert property (@(posedge clk) disable iff (reset)
        shutdown_event_flag |=> held_off)
        else $error("output not held after shutdown");

    AST_HOLD_OFF: assert property (@(posedge clk) disable iff (reset)
        (held_off && !period_start) |=> held_off)
        else $error("restart before period start");

    AST_SYNC_WAIT: assert property (@(posedge clk) disable iff (reset)
        (steer_pending && steer_sync_select && !period_start) |=> $stable(steer_live))
        else $error("steering changed mid period");

    AST_IMMEDIATE: assert property (@(posedge clk) disable iff (reset)
        (bus.wr && bus.addr == REG_STEER && !bus.wdata[SYNC_BIT]) |-> ##[1:5] !steer_pending)
        else $error("immediate steering too late");

    AST_IMM_APPLY: assert property (@(posedge clk) disable iff (reset)
        (steer_pending && !steer_sync_select && instr_edge) |=> steer_live == $past(steer_reg[3:0]))
        else $error("steering not applied at boundary");

    COV_SHUTDOWN: cover property (@(posedge clk) shutdown_event_flag ##1 !shutdown_event_flag);
    COV_DB: cover property (@(posedge clk) pwm_raw && !pwm_db ##1 pwm_db);
    COV_SYNC: cover property (@(posedge clk) steer_pending && steer_sync_select && period_start);
    COV_RESTART: cover property (@(posedge clk) held_off && !shutdown_event_flag && period_start);
endmodule : prds_top
`default_nettype wire

// File: logic/prds_pkg.sv
/*
 * Package for the pulse steering, dead-band and auto-restart block: register
 * indices, field positions, reset values and structs.
 * Assumes one 100 MHz clock and a plain address/strobe register port.
 */
`default_nettype none
package prds_pkg;
    localparam int ADDR_W = 2;
    // Register indices on the plain register port
    localparam logic [1:0] REG_RESTART_DB = 2'h0;
    localparam logic [1:0] REG_STEER = 2'h1;
    localparam logic [1:0] REG_MODE = 2'h2;
    localparam logic [1:0] REG_SHUTDOWN = 2'h3;
    // Reset values
    localparam logic [7:0] RST_RESTART_DB = 8'h00;
    localparam logic [7:0] RST_STEER = 8'h01;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_SHUTDOWN = 8'h00;
    // Field positions
    localparam int RESTART_BIT = 7;
    localparam int SYNC_BIT = 4;
    localparam int EVENT_BIT = 7;
    localparam logic [1:0] MODE_PWM_HI = 2'h3;
    localparam logic [1:0] BRIDGE_SINGLE = 2'h0;
    // Instruction cycle is four oscillator periods; with clk as Fosc
    localparam int OSC_PER_INSTR = 4;
    localparam int PERIOD_W = 8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } prds_bus_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } prds_pins_t;
endpackage : prds_pkg
`default_nettype wire

// File: tb/prds_switch_model.sv
/*
 * Model of the external power switch drivers hanging on the four pins.
 * Assumes each pin carries a pull-down, so a released pin reads low.
 */
`default_nettype none
module prds_switch_model
    import prds_pkg::*;
(
    input wire prds_pkg::prds_pins_t pins, // Pin levels and enables
    output logic [3:0] gate // Level each driver sees
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-downs keep switches off while a pin floats, never the last level
    assign gate = pins.oe & pins.out;
endmodule : prds_switch_model
`default_nettype wire

// File: tb/test_prds_top.sv
/*
 * Self-checking bench for the steering, dead-band and restart block.
 * Assumes a 100 MHz clock and the switch driver model on the pins.
 */
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module test_prds_top;
    timeunit 1ns;
    timeprecision 1ps;
    import prds_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    prds_bus_t bus = '0;
    logic [7:0] rdata;
    logic pwm_raw = 1'b0;
    logic period_start = 1'b0;
    logic shutdown_in = 1'b0;
    logic [3:0] dir = 4'hf;
    logic [3:0] port_out = 4'h0;
    prds_pins_t pins;
    logic [3:0] gate;
    logic [3:0] pol [4] = '{4'hf, 4'h5, 4'ha, 4'h0};
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;

    prds_top #(.DB_W(7)) u_prds_top (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
        .pwm_raw(pwm_raw), .period_start(period_start), .shutdown_in(shutdown_in),
        .pin_direction_bits(dir), .port_out(port_out), .pins(pins));
    prds_switch_model u_prds_switch_model (.pins(pins), .gate(gate));

    always #5 clk = ~clk;

    // Whole run needs well under this many cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            conclude();
        end
    end

    task automatic conclude;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    // A gap cycle follows each access so no strobe is driven twice at one edge
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        `CHK(rdata, e)
    endtask : rd

    // Steering settles within one instruction plus the pin register
    task automatic pin(input logic [3:0] oe, input logic [3:0] g);
        repeat (8) @(posedge clk);
        #1;
        `CHK(pins.oe, oe)
        `CHK(gate, g)
    endtask : pin

    task automatic pulse;
        @(posedge clk);
        period_start <= 1'b1;
        @(posedge clk);
        period_start <= 1'b0;
    endtask : pulse

    task automatic rise(output int c);
        @(posedge clk);
        pwm_raw <= 1'b1;
        c = 0;
        do
        begin
            @(posedge clk);
            #1;
            c++;
        end while (gate[0] !== 1'b1 && c < 100);
    endtask : rise

    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        pin(4'h0, 4'h0);
        rd(REG_RESTART_DB, RST_RESTART_DB);
        rd(REG_STEER, 8'h01);
        rd(REG_MODE, RST_MODE);
        rd(REG_SHUTDOWN, RST_SHUTDOWN);
        @(posedge clk);
        dir <= 4'h0;
        pwm_raw <= 1'b1;
        wr(REG_MODE, 8'h0c);
        // steering enables A and C; B and D stay port pins
        wr(REG_STEER, 8'h05);
        pin(4'hf, 4'h5);
        @(posedge clk);
        port_out <= 4'ha;
        pin(4'hf, 4'hf);
        wr(REG_STEER, 8'h0f);
        pin(4'hf, 4'hf);
        foreach (pol[i])
        begin
            wr(REG_MODE, {4'h0, MODE_PWM_HI, i[1:0]});
            pin(4'hf, pol[i]);
        end
        wr(REG_MODE, 8'h4c);
        pin(4'hf, 4'ha);
        wr(REG_MODE, 8'h08);
        pin(4'hf, 4'ha);
        wr(REG_MODE, 8'h0c);
        rd(REG_MODE, 8'h0c);
        @(posedge clk);
        port_out <= 4'h0;
        wr(REG_STEER, 8'h01);
        pin(4'hf, 4'h1);
        wr(REG_STEER, 8'h12);
        pin(4'hf, 4'h1);
        pulse();
        pin(4'hf, 4'h2);
        wr(REG_STEER, 8'h01);
        pulse();
        pin(4'hf, 4'h1);
        @(posedge clk);
        dir <= 4'h1;
        pin(4'he, 4'h0);
        @(posedge clk);
        dir <= 4'h0;
        pwm_raw <= 1'b0;
        wr(REG_SHUTDOWN, 8'h05);
        @(posedge clk);
        shutdown_in <= 1'b1;
        pin(4'hf, 4'h1);
        @(posedge clk);
        shutdown_in <= 1'b0;
        pin(4'hf, 4'h1);
        rd(REG_SHUTDOWN, 8'h85);
        wr(REG_SHUTDOWN, 8'h05);
        pin(4'hf, 4'h1);
        pulse();
        pin(4'hf, 4'h0);
        wr(REG_RESTART_DB, 8'h80);
        @(posedge clk);
        shutdown_in <= 1'b1;
        pin(4'hf, 4'h1);
        rd(REG_SHUTDOWN, 8'h85);
        @(posedge clk);
        shutdown_in <= 1'b0;
        pin(4'hf, 4'h1);
        rd(REG_SHUTDOWN, 8'h05);
        pulse();
        pin(4'hf, 4'h0);
        wr(REG_RESTART_DB, 8'h03);
        rise(n);
        `CHK((n >= 9 && n <= 16), 1'b1)
        @(posedge clk);
        pwm_raw <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(gate[0], 1'b0)
        wr(REG_RESTART_DB, 8'h00);
        rise(n);
        `CHK((n <= 3), 1'b1)
        wr(REG_STEER, 8'hff);
        rd(REG_STEER, 8'h1f);
        // Reset in mid run; the port side returns its directions to input too
        @(posedge clk);
        reset <= 1'b1;
        dir <= 4'hf;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(REG_STEER, RST_STEER);
        rd(REG_RESTART_DB, RST_RESTART_DB);
        pin(4'h0, 4'h0);
        conclude();
    end
endmodule : test_prds_top
`default_nettype wire
